// ### rtl/scr_receiver.sv
// Receiver sync search, character framing and sync strip logic
`include "scr_params.svh"
module scr_receiver import scr_pkg::*; #(
   parameter int CHAR_W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rx_clk,
   input wire logic rx_serial,
   input wire logic rx_enable,
   input wire logic [CHAR_W-1:0] sync_reg,
   input wire logic odd_parity,
   input wire logic rx_buffer_read_strobe_n,
   output logic [CHAR_W-1:0] receive_data_buffer,
   output logic data_received_flag,
   output logic data_ready,
   output logic match_detect,
   output logic reset_character,
   output logic match_pulse,
   output logic first_in_flop,
   output logic receive_active,
   output logic parity_error_out,
   output logic parity_error_flag,
   output logic receive_error,
   output logic overrun_error,
   output logic receive_done,
   output logic rx_interrupt_req,
   output logic clear_status_and_data
);
   typedef struct packed {
      logic [1:0] clk_sy;
      logic [1:0] ser_sy;
      logic [1:0] strb_sy;
      logic clk_prev;
      logic strb_prev;
      logic armed;
      scr_state_t st;
      logic [`SCR_CNT_W-1:0] bitcnt;
      logic [CHAR_W:0] shreg;
      logic [CHAR_W-1:0] rdbuf;
      logic dr;
      logic drdy;
      logic mdet;
      logic rstchar;
      logic first_in;
      logic act;
      logic pe;
      logic perr;
      logic ovr;
      logic done;
      logic clr;
      logic [`SCR_TMR_W-1:0] pe_tmr;
   } scr_state_s_t;

   scr_state_s_t s_q, s_d;
   logic match_fire, match_active, match_end;
   logic drr_fire, drr_active, drr_end;

   function automatic logic par_ok(input logic [CHAR_W:0] c, input logic odd);
      par_ok = ((^c) == odd);
   endfunction

   // ----------------------------------------
   // One-shots
   // ----------------------------------------
   scr_oneshot #(.CYCLES(`SCR_ONESHOT_CYC)) u_match (
      .clk(clk), .rst_n(rst_n), .trig(match_fire), .active(match_active), .done(match_end)
   );
   scr_oneshot #(.CYCLES(`SCR_ONESHOT_CYC)) u_drr (
      .clk(clk), .rst_n(rst_n), .trig(drr_fire), .active(drr_active), .done(drr_end)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   logic bit_tick, clk_fall, strb_fall, strb_rise;
   logic [CHAR_W:0] sh_n;
   logic [CHAR_W-1:0] ch;
   logic is_sync, good;
   always_comb begin
      s_d = s_q;
      s_d.clk_sy = {s_q.clk_sy[0], rx_clk};
      s_d.ser_sy = {s_q.ser_sy[0], rx_serial};
      s_d.strb_sy = {s_q.strb_sy[0], rx_buffer_read_strobe_n};
      s_d.clk_prev = s_q.clk_sy[1];
      s_d.strb_prev = s_q.strb_sy[1];
      // Sample on rising receive clock near bit center
      bit_tick = s_q.clk_sy[1] & ~s_q.clk_prev;
      clk_fall = ~s_q.clk_sy[1] & s_q.clk_prev;
      strb_fall = ~s_q.strb_sy[1] & s_q.strb_prev;
      strb_rise = s_q.strb_sy[1] & ~s_q.strb_prev;
      sh_n = {s_q.ser_sy[1], s_q.shreg[CHAR_W:1]};
      ch = sh_n[CHAR_W-1:0];
      is_sync = (ch == sync_reg);
      good = par_ok(sh_n, odd_parity);
      s_d.clr = drr_fire;
      match_fire = 1'b0;
      drr_fire = 1'b0;
      // Enable re-arms only on a falling receive clock while data-ready is clear
      if (!rx_enable) begin
         s_d.armed = 1'b0;
         s_d.st = SCR_SEARCH;
         s_d.act = 1'b0;
         s_d.first_in = 1'b0;
      end else if (clk_fall && !s_q.drdy) begin
         s_d.armed = 1'b1;
      end
      if (match_end) begin
         s_d.first_in = 1'b1;
      end
      if (bit_tick && s_q.armed && rx_enable) begin
         s_d.shreg = sh_n;
         case (s_q.st)
            SCR_SEARCH: begin
               s_d.rdbuf = ch;
               if (is_sync && good) begin
                  s_d.mdet = 1'b1;
                  s_d.rstchar = 1'b1;
                  match_fire = 1'b1;
                  s_d.st = SCR_FRAME;
                  s_d.bitcnt = '0;
               end
            end
            SCR_FRAME: begin
               if (s_q.bitcnt == `SCR_CNT_W'(CHAR_W)) begin
                  s_d.bitcnt = '0;
                  s_d.rdbuf = ch;
                  s_d.mdet = is_sync;
                  s_d.ovr = s_q.ovr | s_q.dr;
                  if (!good) begin
                     s_d.pe = 1'b1;
                     s_d.perr = 1'b1;
                     s_d.rstchar = 1'b0;
                     s_d.pe_tmr = `SCR_TMR_W'(`SCR_PE_DLY_CYC);
                  end else begin
                     s_d.rstchar = is_sync;
                     s_d.dr = 1'b1;
                  end
               end else begin
                  s_d.bitcnt = s_q.bitcnt + `SCR_CNT_W'(1);
               end
            end
            default: s_d.st = SCR_SEARCH;
         endcase
      end
      // Delayed data-received after parity error
      if (s_q.pe_tmr != '0) begin
         s_d.pe_tmr = s_q.pe_tmr - `SCR_TMR_W'(1);
         if (s_q.pe_tmr == `SCR_TMR_W'(1)) begin
            s_d.dr = 1'b1;
         end
      end
      // Data-ready follows the flag and holds through the one-shot
      if (s_q.dr && !s_q.drdy) begin
         s_d.drdy = 1'b1;
         s_d.armed = 1'b0;
         if (!s_q.act && s_q.first_in && s_q.rstchar && !s_q.perr) begin
            drr_fire = 1'b1;
         end else if (s_q.act && s_q.rstchar && !s_q.perr) begin
            drr_fire = 1'b1;
         end else if (s_q.act) begin
            s_d.done = 1'b1;
         end
      end
      if (strb_fall) begin
         drr_fire = 1'b1;
      end
      if (s_q.clr) begin
         s_d.dr = 1'b0;
         s_d.pe = 1'b0;
         s_d.perr = 1'b0;
         s_d.ovr = 1'b0;
      end
      if (drr_end) begin
         s_d.drdy = 1'b0;
         if (!s_q.act && s_q.first_in) begin
            s_d.act = 1'b1;
         end
      end
      if (strb_rise) begin
         s_d.done = 1'b0;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{st: SCR_SEARCH, clk_sy: 2'h0, ser_sy: 2'h0, strb_sy: 2'h3, strb_prev: 1'b1, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Outputs straight from flops, except match_pulse decoded from the one-shot count
   // ----------------------------------------
   assign receive_data_buffer = s_q.rdbuf;
   assign data_received_flag = s_q.dr;
   assign data_ready = s_q.drdy;
   assign match_detect = s_q.mdet;
   assign reset_character = s_q.rstchar;
   assign match_pulse = match_active;
   assign first_in_flop = s_q.first_in;
   assign receive_active = s_q.act;
   assign parity_error_out = s_q.pe;
   assign parity_error_flag = s_q.perr;
   assign receive_error = s_q.perr;
   assign overrun_error = s_q.ovr;
   assign receive_done = s_q.done;
   assign rx_interrupt_req = s_q.done;
   assign clear_status_and_data = s_q.clr;
endmodule

// ### rtl/scr_params.svh
// Constants for the sync character receiver framing block
`ifndef SCR_PARAMS_SVH
`define SCR_PARAMS_SVH
`define SCR_CLK_NS 100
`define SCR_ONESHOT_NS 400
`define SCR_ONESHOT_CYC (((`SCR_ONESHOT_NS) / (`SCR_CLK_NS)) < 1 ? 1 : ((`SCR_ONESHOT_NS) / (`SCR_CLK_NS)))
`define SCR_PE_DLY_NS 200
`define SCR_PE_DLY_CYC (((`SCR_PE_DLY_NS) / (`SCR_CLK_NS)) < 1 ? 1 : ((`SCR_PE_DLY_NS) / (`SCR_CLK_NS)))
`define SCR_CNT_W 4
`define SCR_TMR_W 4
`endif

// ### rtl/scr_pkg.sv
// Types for the sync character receiver framing block
package scr_pkg;
   typedef enum logic [3:0] {
      SCR_SEARCH = 4'h1,
      SCR_FRAME  = 4'h2,
      SCR_WAIT   = 4'h4,
      SCR_DRDY   = 4'h8
   } scr_state_t;
endpackage

// ### rtl/scr_oneshot.sv
// Retriggerable pulse stretcher used for the one-shots
`include "scr_params.svh"
module scr_oneshot #(
   parameter int CYCLES = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic trig,
   output logic active,
   output logic done
);
   typedef struct packed {
      logic [`SCR_TMR_W-1:0] cnt;
      logic done;
   } scr_os_t;
   scr_os_t s_q, s_d;
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      if (trig) begin
         s_d.cnt = `SCR_TMR_W'(CYCLES);
      end else if (s_q.cnt != '0) begin
         s_d.cnt = s_q.cnt - `SCR_TMR_W'(1);
         s_d.done = (s_q.cnt == `SCR_TMR_W'(1));
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign active = (s_q.cnt != '0);
   assign done = s_q.done;
endmodule

// ### tb/scr_receiver_sva.sv
// Checker for the sync character receiver framing block
module scr_receiver_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rx_buffer_read_strobe_n,
   input wire logic data_received_flag,
   input wire logic data_ready,
   input wire logic match_pulse,
   input wire logic first_in_flop,
   input wire logic receive_active,
   input wire logic parity_error_out,
   input wire logic parity_error_flag,
   input wire logic receive_error,
   input wire logic reset_character,
   input wire logic receive_done,
   input wire logic rx_interrupt_req,
   input wire logic clear_status_and_data
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_clr; clear_status_and_data |=> !data_received_flag && !clear_status_and_data; endproperty
   a_clr: assert property (p_clr) else $error("clear pulse misbehaved");
   property p_rdy; clear_status_and_data && data_ready |-> ##[1:6] !data_ready; endproperty
   a_rdy: assert property (p_rdy) else $error("data ready not released");
   property p_mp; $rose(match_pulse) |-> match_pulse[*4] ##1 !match_pulse; endproperty
   a_mp: assert property (p_mp) else $error("match pulse width wrong");
   property p_fi; $fell(match_pulse) |-> ##[0:1] first_in_flop; endproperty
   a_fi: assert property (p_fi) else $error("first in not set");
   property p_act; $rose(receive_active) |-> $past(data_ready) || $past(data_ready, 2); endproperty
   a_act: assert property (p_act) else $error("active without data ready");
   property p_gate; $rose(receive_done) |-> $past(receive_active) && rx_interrupt_req; endproperty
   a_gate: assert property (p_gate) else $error("done before sync");
   property p_pe; $rose(parity_error_out) |-> ##[1:3] data_received_flag; endproperty
   a_pe: assert property (p_pe) else $error("flag late after parity error");
   property p_err; $rose(parity_error_out) |-> ##[0:2] (parity_error_flag && receive_error && !reset_character);
   endproperty
   a_err: assert property (p_err) else $error("error did not cancel strip");
   property p_done; $rose(rx_buffer_read_strobe_n) |-> ##[1:5] !receive_done; endproperty
   a_done: assert property (p_done) else $error("done not cleared");
   c_act: cover property ($rose(receive_active));
   c_done: cover property ($rose(receive_done));
   c_pe: cover property ($rose(parity_error_out));
endmodule

// ### tb/scr_line_model.sv
// Serial line and host program model for the sync receiver
module scr_line_model (
   input wire logic clk,
   output logic rx_clk,
   output logic rx_serial,
   output logic rx_buffer_read_strobe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      rx_clk = 1'h1;
      rx_serial = 1'h1;
      rx_buffer_read_strobe_n = 1'h1;
   end
   // One unit LSB first, parity last; clock idles high between units
   task automatic send(input logic [8:0] u);
      for (int i = 0; i < 9; i++) begin
         @(posedge clk);
         rx_clk <= 1'h0;
         rx_serial <= u[i];
         repeat (10) @(posedge clk);
         rx_clk <= 1'h1;
         repeat (9) @(posedge clk);
      end
      @(posedge clk);
      rx_serial <= ~rx_serial;
   endtask
   // Strobe held long enough to cross the synchronizer
   task automatic read_buf;
      @(posedge clk);
      rx_buffer_read_strobe_n <= 1'h0;
      repeat (6) @(posedge clk);
      rx_buffer_read_strobe_n <= 1'h1;
      repeat (12) @(posedge clk);
   endtask
endmodule

// ### tb/testbench.sv
// Self-checking bench for the sync character receiver
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic rx_enable = 1'h0;
   logic odd_parity = 1'h0;
   logic [7:0] sync_reg = 8'h16;
   logic rx_clk, rx_serial, rx_buffer_read_strobe_n;
   logic [7:0] receive_data_buffer;
   logic data_received_flag, data_ready, match_detect, reset_character, match_pulse, first_in_flop;
   logic receive_active, parity_error_out, parity_error_flag, receive_error, overrun_error;
   logic receive_done, rx_interrupt_req, clear_status_and_data;
   int err_total = 0;
   int n_checks = 0;
   int seed = 31422;
   logic [7:0] c;
   always #50 clk = ~clk;
   scr_receiver #(.CHAR_W(8)) i_scr_receiver (.clk, .rst_n, .rx_clk, .rx_serial, .rx_enable, .sync_reg,
      .odd_parity, .rx_buffer_read_strobe_n, .receive_data_buffer, .data_received_flag, .data_ready,
      .match_detect, .reset_character, .match_pulse, .first_in_flop, .receive_active, .parity_error_out,
      .parity_error_flag, .receive_error, .overrun_error, .receive_done, .rx_interrupt_req,
      .clear_status_and_data);
   scr_line_model i_scr_line_model (.clk, .rx_clk, .rx_serial, .rx_buffer_read_strobe_n);
   // ----------------------------------------
   // Expectations and reporting
   // ----------------------------------------
   function automatic logic [8:0] unit(input logic [7:0] d, input logic bad);
      return {^d ^ odd_parity ^ bad, d};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("Checks %0d, errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Gap lets data ready drop so the next falling clock rearms
   task automatic rx_unit(input logic [7:0] d, input logic bad);
      i_scr_line_model.send(unit(d, bad));
      repeat (12) @(posedge clk);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      odd_parity <= 1'($random(seed));
      rx_enable <= 1'h1;
      repeat (3) @(posedge clk);
      // First unit may lose its leading bit, so three are sent
      repeat (3) rx_unit(sync_reg, 1'h0);
      chk(receive_active, 1'h1);
      chk(first_in_flop, 1'h1);
      chk(receive_done, 1'h0);
      rx_unit(sync_reg, 1'h0);
      chk(receive_done, 1'h0);
      chk(data_received_flag, 1'h0);
      chk(overrun_error, 1'h0);
      chk(receive_data_buffer, sync_reg);
      rx_unit(sync_reg, 1'h1);
      chk(receive_done, 1'h1);
      chk(parity_error_flag, 1'h1);
      chk(rx_interrupt_req, 1'h1);
      chk(receive_data_buffer, sync_reg);
      i_scr_line_model.read_buf();
      chk(receive_done, 1'h0);
      chk(parity_error_flag, 1'h0);
      chk(data_received_flag, 1'h0);
      for (int i = 0; i < 6; i++) begin
         c = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
         if (c == sync_reg)
            c = ~c;
         rx_unit(c, 1'h0);
         chk(receive_done, 1'h1);
         chk(match_detect, 1'h0);
         chk(receive_data_buffer, c);
         i_scr_line_model.read_buf();
         chk(receive_done, 1'h0);
      end
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      print_verdict();
   end
endmodule
bind scr_receiver scr_receiver_sva i_scr_receiver_sva (.clk, .rst_n, .rx_buffer_read_strobe_n,
   .data_received_flag, .data_ready, .match_pulse, .first_in_flop, .receive_active, .parity_error_out,
   .parity_error_flag, .receive_error, .reset_character, .receive_done, .rx_interrupt_req,
   .clear_status_and_data);
